// >>> ppp_mem.sv
// memory: single-port word store with registered read data
`timescale 1ns/1ps
module ppp_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // clock
  input wire logic core_clk_i,
  // access
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // elaboration check on the array shape
  if (AW < 1 || DW < 1) $error("ppp_mem: bad size");

  // write, and registered read of the word held before that write
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// >>> ppp_pkg.sv
// package: constants for the parallel memory programming port
package ppp_pkg;
  // action select codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // command bytes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
  // reset and erased values, entry pattern
  localparam logic [7:0] LOCK_ERASED = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ENTRY_QUIET_NS = 100;
  localparam int ENTRY_QUIET_CYC = (ENTRY_QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ENTRY_TOGGLES = 6;
  localparam int PROG_TIME_CYC = 64;
endpackage

// >>> ppp_port.sv
// top: device side of the parallel high-voltage programming port
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - load strobe rise decodes action: address, data, command, idle
// - first byte select picks low or high byte
// - second byte select picks low or second high byte
// - done flag low while busy, high when ready
// - data bus driven only while output enable low
// - write strobe or output enable runs the loaded command
// - command byte encodings for erase, writes and reads
// - entry pattern change within 100 ns of high voltage aborts entry
// - command and address stay loaded across accesses
// - chip erase clears flash, eeprom, locks; fuses unchanged
// - lock bits cleared only after flash erase completes
// - keep-eeprom fuse preserves eeprom through chip erase
// - erase starts on write strobe, busy until done
// - flash data collects in page buffer, page written at once
// - low and high data bytes latched by buffer latch pulse
// - low address bits index word; upper bits select page
// - write strobe after address high starts page program, busy
// - no-operation command ends page programming, clears write state
// - page holds 16 or 32 words
module ppp_port #(
  parameter int PAGE_WORDS = 32,
  parameter int FLASH_AW = 12,
  parameter int EE_AW = 9,
  parameter int PROG_CYC = ppp_pkg::PROG_TIME_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // entry: high voltage present on reset pin
  input wire logic hv_reset_i,
  // programming pins
  input wire logic load_strobe_i,
  input wire logic action_sel_0_i,
  input wire logic action_sel_1_i,
  input wire logic buffer_latch_pulse_i,
  input wire logic wr_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic [7:0] data_oe_n_o,
  output logic done_flag_o,
  // status
  input wire logic keep_eeprom_fuse_i,
  output logic prog_mode_o,
  output logic [7:0] lock_bits_o,
  output logic [7:0] fuse_low_o,
  output logic [7:0] fuse_high_o,
  output logic [7:0] fuse_ext_o
);
  localparam int WIB = $clog2(PAGE_WORDS);
  // elaboration checks on sizes the logic can serve
  if (PAGE_WORDS != 16 && PAGE_WORDS != 32) $error("ppp_port: page size");
  if (FLASH_AW < 9 || FLASH_AW > 16 || EE_AW < 8 || EE_AW > 16 || PROG_CYC < 1) $error("ppp_port: bad size");

  typedef enum logic [2:0] {
    PPP_OFF = 3'b000, PPP_QUIET = 3'b001, PPP_IDLE = 3'b010,
    PPP_ERASE = 3'b011, PPP_PAGE = 3'b100, PPP_BYTE = 3'b101
  } ppp_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation: every pin is from outside this clock
  logic [15:0] s;
  logic [7:0] din;
  logic ls, a0, a1, bl, wr_n, oe_n, hv, kf;
  ppp_sync #(.W(16)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({hv_reset_i, keep_eeprom_fuse_i, load_strobe_i, action_sel_0_i, action_sel_1_i, buffer_latch_pulse_i,
          wr_n_i, oe_n_i, data_i}),
    .q_o(s)
  );
  assign {hv, kf, ls, a0, a1, bl, wr_n, oe_n, din} = s;
  // edge detection on synchronised levels
  logic ls_q, bl_q, wr_q, hv_q;
  logic ls_rise, bl_rise, wr_fall;
  assign ls_rise = ls & ~ls_q;
  assign bl_rise = bl & ~bl_q;
  assign wr_fall = ~wr_n & wr_q;

  //////////////////////////////////////////////////////////////////////////////
  // state
  ppp_state_t state, next_state;
  logic [7:0] cmd, next_cmd, addr_lo, next_addr_lo, addr_hi, next_addr_hi;
  logic [7:0] dat_lo, next_dat_lo, dat_hi, next_dat_hi;
  logic [7:0] lock, next_lock, fl, next_fl, fh, next_fh, fe, next_fe;
  logic [15:0] cnt, next_cnt;
  logic [3:0] toggles, next_toggles;
  logic [15:0] sweep, next_sweep;
  logic keep_ee, next_keep_ee;
  logic [PAGE_WORDS-1:0] pb_valid, next_pb_valid;

  // page buffer, flash and eeprom arrays
  logic [WIB-1:0] pb_addr;
  logic pb_we;
  logic [15:0] pb_rd, fl_rd, fl_wd, wa;
  logic [FLASH_AW-1:0] fl_addr;
  logic fl_we;
  logic [7:0] ee_rd, ee_wd;
  logic [EE_AW-1:0] ee_addr;
  logic ee_we;

  ppp_mem #(.AW(WIB), .DW(16)) u_page (
    .core_clk_i(core_clk_i), .we_i(pb_we), .addr_i(pb_addr), .wdata_i({dat_hi, dat_lo}), .rdata_o(pb_rd)
  );
  ppp_mem #(.AW(FLASH_AW), .DW(16)) u_flash (
    .core_clk_i(core_clk_i), .we_i(fl_we), .addr_i(fl_addr), .wdata_i(fl_wd), .rdata_o(fl_rd)
  );
  ppp_mem #(.AW(EE_AW), .DW(8)) u_eeprom (
    .core_clk_i(core_clk_i), .we_i(ee_we), .addr_i(ee_addr), .wdata_i(ee_wd), .rdata_o(ee_rd)
  );

  // word address from the two address bytes
  assign wa = {addr_hi, addr_lo};
  //////////////////////////////////////////////////////////////////////////////
  // memory port steering
  always_comb begin
    pb_we = (state == PPP_IDLE) && bl_rise && (cmd == ppp_pkg::CMD_WR_FLASH);
    pb_addr = (state == PPP_PAGE) ? cnt[WIB-1:0] : addr_lo[WIB-1:0];
    fl_we = 1'b0;
    fl_wd = {ppp_pkg::ERASED_BYTE, ppp_pkg::ERASED_BYTE};
    fl_addr = wa[FLASH_AW-1:0];
    ee_we = 1'b0;
    ee_wd = ppp_pkg::ERASED_BYTE;
    ee_addr = wa[EE_AW-1:0];
    if (state == PPP_ERASE) begin
      fl_addr = sweep[FLASH_AW-1:0];
      fl_we = ({1'b0, sweep} < (17'h00001 << FLASH_AW));
      ee_addr = sweep[EE_AW-1:0];
      ee_we = !keep_ee && ({1'b0, sweep} < (17'h00001 << EE_AW));
    end else if (state == PPP_PAGE) begin
      // word bits lag the buffer read by one cycle; unlatched words are skipped and stay erased
      fl_addr = {wa[FLASH_AW-1:WIB], cnt[WIB-1:0] - WIB'(1)};
      fl_wd = pb_rd;
      fl_we = (cnt != 16'h0000) && pb_valid[cnt[WIB-1:0] - WIB'(1)];
    end else if (state == PPP_BYTE) begin
      ee_wd = dat_lo;
      ee_we = (cnt == 16'h0000) && (cmd == ppp_pkg::CMD_WR_EEPROM);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command, address, data and control next values
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    next_dat_lo = dat_lo;
    next_dat_hi = dat_hi;
    next_lock = lock;
    next_fl = fl;
    next_fh = fh;
    next_fe = fe;
    next_cnt = cnt;
    next_toggles = toggles;
    next_sweep = sweep;
    next_keep_ee = keep_ee;
    next_pb_valid = (state == PPP_BYTE) ? '0 : pb_valid; // buffer empties once a write finishes
    if (pb_we) next_pb_valid[pb_addr] = 1'b1;
    case (state)
      PPP_OFF: begin
        if (ls_rise && toggles != 4'hF) next_toggles = toggles + 4'h1;
        // rise of high voltage with pattern zero and enough toggles
        if (hv && !hv_q && toggles >= 4'(ppp_pkg::ENTRY_TOGGLES) &&
            {bl, a1, a0, wr_n} == ppp_pkg::ENTRY_PATTERN) begin
          next_state = PPP_QUIET;
          next_cnt = 16'h0000;
        end
      end
      PPP_QUIET: begin
        if ({bl, a1, a0, wr_n} != ppp_pkg::ENTRY_PATTERN || !hv) begin
          next_state = PPP_OFF;
          next_toggles = 4'h0;
        end else if (cnt == 16'(ppp_pkg::ENTRY_QUIET_CYC - 1)) begin
          next_state = PPP_IDLE;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      PPP_IDLE: begin
        next_keep_ee = kf;
        if (ls_rise) begin
          case ({a1, a0})
            ppp_pkg::ACT_ADDR: begin
              if (bl) next_addr_hi = din;
              else next_addr_lo = din;
            end
            ppp_pkg::ACT_DATA: begin
              if (bl) next_dat_hi = din;
              else next_dat_lo = din;
            end
            ppp_pkg::ACT_CMD: begin
              next_cmd = din;
              if (din == ppp_pkg::CMD_NOP) next_pb_valid = '0;
            end
            default: begin
            end
          endcase
        end else if (wr_fall) begin
          next_cnt = 16'h0000;
          case (cmd)
            ppp_pkg::CMD_CHIP_ERASE: begin
              next_state = PPP_ERASE;
              next_sweep = 16'h0000;
            end
            ppp_pkg::CMD_WR_FLASH: next_state = PPP_PAGE;
            ppp_pkg::CMD_WR_EEPROM: next_state = PPP_BYTE;
            ppp_pkg::CMD_WR_FUSE: begin
              next_state = PPP_BYTE;
              case ({a1, bl})
                2'b01: next_fh = dat_lo;
                2'b10: next_fe = dat_lo;
                default: next_fl = dat_lo;
              endcase
            end
            ppp_pkg::CMD_WR_LOCK: begin
              next_state = PPP_BYTE;
              next_lock = lock & dat_lo;
            end
            default: begin
            end
          endcase
        end
      end
      PPP_ERASE: begin
        next_sweep = sweep + 16'h0001;
        if (sweep == 16'hFFFF) begin
          next_lock = ppp_pkg::LOCK_ERASED;
          next_state = PPP_IDLE;
        end
      end
      PPP_PAGE: begin
        next_cnt = (cnt == 16'(PAGE_WORDS)) ? 16'h0000 : cnt + 16'h0001; // program time then runs in full
        if (cnt == 16'(PAGE_WORDS)) next_state = PPP_BYTE;
      end
      PPP_BYTE: begin
        next_cnt = cnt + 16'h0001;
        if (cnt >= 16'(PROG_CYC)) next_state = PPP_IDLE;
      end
      default: next_state = PPP_OFF;
    endcase
    if (!hv && state != PPP_OFF) begin
      next_state = PPP_OFF;
      next_toggles = 4'h0;
    end
  end

  // registers; command and address stay put between accesses
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= PPP_OFF;
      cmd <= ppp_pkg::CMD_NOP;
      addr_lo <= 8'h00;
      addr_hi <= 8'h00;
      dat_lo <= 8'h00;
      dat_hi <= 8'h00;
      lock <= ppp_pkg::LOCK_ERASED;
      fl <= 8'hFF;
      fh <= 8'hFF;
      fe <= 8'hFF;
      cnt <= 16'h0000;
      toggles <= 4'h0;
      sweep <= 16'h0000;
      keep_ee <= 1'b0;
      pb_valid <= '0;
      ls_q <= 1'b0;
      bl_q <= 1'b0;
      wr_q <= 1'b0;
      hv_q <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
      dat_lo <= next_dat_lo;
      dat_hi <= next_dat_hi;
      lock <= next_lock;
      fl <= next_fl;
      fh <= next_fh;
      fe <= next_fe;
      cnt <= next_cnt;
      toggles <= next_toggles;
      sweep <= next_sweep;
      keep_ee <= next_keep_ee;
      pb_valid <= next_pb_valid;
      ls_q <= ls;
      bl_q <= bl;
      wr_q <= wr_n;
      hv_q <= hv;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data and pin drive
  logic [7:0] next_rd, rd;
  always_comb begin
    next_rd = 8'h00;
    case (cmd)
      ppp_pkg::CMD_RD_FLASH: next_rd = bl ? fl_rd[15:8] : fl_rd[7:0];
      ppp_pkg::CMD_RD_EEPROM: next_rd = ee_rd;
      ppp_pkg::CMD_RD_FUSE: begin
        case ({a1, bl})
          2'b00: next_rd = fl;
          2'b11: next_rd = fh;
          2'b10: next_rd = fe;
          default: next_rd = lock;
        endcase
      end
      default: next_rd = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd <= 8'h00;
    end else begin
      rd <= next_rd;
    end
  end

  assign data_o = rd;
  assign data_oe_n_o = {8{oe_n || state == PPP_OFF || state == PPP_QUIET}};
  assign done_flag_o = !((state == PPP_ERASE) || (state == PPP_PAGE) || (state == PPP_BYTE));
  assign prog_mode_o = (state != PPP_OFF) && (state != PPP_QUIET);
  assign lock_bits_o = lock;
  assign fuse_low_o = fl;
  assign fuse_high_o = fh;
  assign fuse_ext_o = fe;
endmodule

// >>> ppp_port_monitor.sv
// checker: port-level assertions for the programming port
`timescale 1ns/1ps
module ppp_port_monitor #(
  parameter int PAGE_WORDS = 32,
  parameter int PROG_CYC = 64
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic hv_reset_i,
  input wire logic action_sel_0_i,
  input wire logic action_sel_1_i,
  input wire logic buffer_latch_pulse_i,
  input wire logic wr_n_i,
  input wire logic oe_n_i,
  // outputs watched
  input wire logic [7:0] data_oe_n_o,
  input wire logic done_flag_o,
  input wire logic prog_mode_o,
  input wire logic [7:0] lock_bits_o
);
  localparam int BUSY_MAX = 65536 + PAGE_WORDS + PROG_CYC + 8;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  int busy_cnt;
  int next_busy_cnt;
  int quiet_cnt;
  int next_quiet_cnt;
  //////////////////////////////////////////////////////////////////////////////
  // busy length and quiet entry pattern under high voltage, counted at the pins
  always_comb begin
    next_busy_cnt = done_flag_o ? 0 : busy_cnt + 1;
    next_quiet_cnt = (hv_reset_i && !{buffer_latch_pulse_i, action_sel_1_i, action_sel_0_i, wr_n_i}) ? quiet_cnt + 1 : 0;
  end
  // registers only
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt <= 0;
      quiet_cnt <= 0;
    end else begin
      busy_cnt <= next_busy_cnt;
      quiet_cnt <= next_quiet_cnt;
    end
  end
  // a programming operation: flag falls, then stays low
  sequence s_busy_start;
    $fell(done_flag_o);
  endsequence
  sequence s_held_low;
    !done_flag_o [*8];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  // pin latency is two cycles, so four steady cycles settle the bus enable
  hiz_idle_a: assert property (oe_n_i [*4] |-> data_oe_n_o == 8'hFF) else $error("bus driven with oe high");
  drive_rd_a: assert property ((prog_mode_o && !oe_n_i) [*4] |-> data_oe_n_o == 8'h00) else $error("bus not driven");
  off_hiz_a: assert property (!prog_mode_o |-> data_oe_n_o == 8'hFF) else $error("bus driven outside mode");
  ready_off_a: assert property (!prog_mode_o |-> done_flag_o) else $error("busy outside mode");
  busy_wr_a: assert property (s_busy_start |-> !wr_n_i && prog_mode_o) else $error("busy without write");
  busy_min_a: assert property (s_busy_start |-> s_held_low) else $error("busy too short");
  busy_max_a: assert property (busy_cnt <= BUSY_MAX) else $error("busy too long");
  entry_quiet_a: assert property ($rose(prog_mode_o) |-> quiet_cnt >= 17) else $error("entry without quiet");
  lock_busy_a: assert property ($changed(lock_bits_o) |-> $changed(done_flag_o)) else $error("locks moved idle");
  lock_clr_a: assert property (lock_bits_o == 8'hFF && !$stable(lock_bits_o) |-> ##[0:3] done_flag_o)
    else $error("locks cleared early");
endmodule

bind ppp_port ppp_port_monitor #(.PAGE_WORDS(PAGE_WORDS), .PROG_CYC(PROG_CYC)) i_mon (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .hv_reset_i(hv_reset_i),
  .action_sel_0_i(action_sel_0_i),
  .action_sel_1_i(action_sel_1_i),
  .buffer_latch_pulse_i(buffer_latch_pulse_i),
  .wr_n_i(wr_n_i),
  .oe_n_i(oe_n_i),
  .data_oe_n_o(data_oe_n_o),
  .done_flag_o(done_flag_o),
  .prog_mode_o(prog_mode_o),
  .lock_bits_o(lock_bits_o)
);

// >>> ppp_prog_model.sv
// partner: behavioural high-voltage programmer driving the port pins
`timescale 1ns/1ps
module ppp_prog_model (
  // clock and device answers
  input wire logic core_clk_i,
  input wire logic done_flag_i,
  input wire logic [7:0] bus_i,
  // programming pins
  output logic hv_o,
  output logic load_strobe_o,
  output logic action_sel_0_o,
  output logic action_sel_1_o,
  output logic buffer_latch_pulse_o,
  output logic wr_n_o,
  output logic oe_n_o,
  output logic [7:0] drv_o
);
  // pattern pins start at zero so entry can begin at once
  initial begin
    {hv_o, load_strobe_o, action_sel_0_o, action_sel_1_o, buffer_latch_pulse_o, wr_n_o} = 6'h00;
    oe_n_o = 1'b1;
    drv_o = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // every level stands 50 cycles, twice the minimum pulse width
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] b);
    @(posedge core_clk_i);
    {action_sel_1_o, action_sel_0_o, buffer_latch_pulse_o} <= {act, bs1};
    drv_o <= b;
    hold(50);
    load_strobe_o <= 1'b1;
    hold(50);
    load_strobe_o <= 1'b0;
    hold(50);
  endtask
  // selects for fuse writes
  task automatic pins(input logic s1, input logic bl);
    @(posedge core_clk_i);
    {action_sel_1_o, buffer_latch_pulse_o} <= {s1, bl};
    hold(50);
  endtask
  // low then high, so the latch always sees a fresh rising edge
  task automatic latch();
    @(posedge core_clk_i);
    buffer_latch_pulse_o <= 1'b0;
    hold(50);
    buffer_latch_pulse_o <= 1'b1;
    hold(50);
  endtask
  // write strobe, then no new command until ready returns
  task automatic wr(output logic busy);
    busy = 1'b0;
    @(posedge core_clk_i);
    wr_n_o <= 1'b0;
    repeat (50) begin
      @(posedge core_clk_i);
      busy = busy | (done_flag_i === 1'b0);
    end
    wr_n_o <= 1'b1;
    for (int n = 0; n < 70000 && done_flag_i !== 1'b1; n++) @(posedge core_clk_i);
  endtask
  task automatic rd(input logic bs1, output logic [7:0] b);
    @(posedge core_clk_i);
    buffer_latch_pulse_o <= bs1;
    oe_n_o <= 1'b0;
    hold(50);
    b = bus_i;
    oe_n_o <= 1'b1;
    hold(50);
  endtask
  // spoil moves a pattern pin inside the quiet window to force a failed entry
  task automatic enter(input logic spoil);
    @(posedge core_clk_i);
    {hv_o, action_sel_1_o, action_sel_0_o, buffer_latch_pulse_o, wr_n_o} <= 5'h00;
    repeat (6) begin
      hold(50);
      load_strobe_o <= 1'b1;
      hold(50);
      load_strobe_o <= 1'b0;
    end
    hold(50);
    hv_o <= 1'b1;
    hold(5);
    wr_n_o <= spoil;
    hold(spoil ? 100 : 10000);
    wr_n_o <= 1'b1;
    hold(50);
  endtask
endmodule

// >>> ppp_sync.sv
// synchroniser: two-flop capture of asynchronous pin levels
`timescale 1ns/1ps
module ppp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// >>> tb_top.sv
// testbench: entry, fuse, lock, erase and flash page scenarios
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i, rst_n_i, keep, hv, strobe, sel0, sel1, latch, wr_n, oe_n, done, mode, busy;
  logic [7:0] drv, bus, dout, doe_n, locks, f_lo, f_hi, f_ext, got;
  int err_total;
  int checked;
  // released bits show the programmer's last byte, inverted while output enable is low
  always_comb for (int i = 0; i < 8; i++) bus[i] = !doe_n[i] ? dout[i] : (oe_n ? drv[i] : !drv[i]);
  ppp_port #(.PAGE_WORDS(16), .PROG_CYC(8)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hv_reset_i(hv),
    .load_strobe_i(strobe), .action_sel_0_i(sel0), .action_sel_1_i(sel1), .buffer_latch_pulse_i(latch),
    .wr_n_i(wr_n), .oe_n_i(oe_n), .data_i(bus), .data_o(dout), .data_oe_n_o(doe_n), .done_flag_o(done),
    .keep_eeprom_fuse_i(keep), .prog_mode_o(mode), .lock_bits_o(locks), .fuse_low_o(f_lo),
    .fuse_high_o(f_hi), .fuse_ext_o(f_ext));
  ppp_prog_model i_prog (.core_clk_i(core_clk_i), .done_flag_i(done), .bus_i(bus), .hv_o(hv), .load_strobe_o(strobe),
    .action_sel_0_o(sel0), .action_sel_1_o(sel1), .buffer_latch_pulse_o(latch), .wr_n_o(wr_n), .oe_n_o(oe_n),
    .drv_o(drv));
  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset();
    cmp8("ready", 8'h01, {7'h00, done});
    cmp8("locks", ppp_pkg::LOCK_ERASED, locks);
    cmp8("bus enable", 8'hFF, doe_n);
  endtask
  task automatic t_entry();
    i_prog.enter(1'b1);
    cmp8("spoiled entry", 8'h00, {7'h00, mode});
    i_prog.enter(1'b0);
    cmp8("entry", 8'h01, {7'h00, mode});
  endtask
  // one command load serves all three fuse bytes
  task automatic t_fuse();
    logic [7:0] val [3] = '{8'h9A, 8'hB5, 8'hFE};
    i_prog.load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      i_prog.load(ppp_pkg::ACT_DATA, 1'b0, val[i]);
      i_prog.pins(i == 2, i == 1);
      i_prog.wr(busy);
      cmp8("fuse busy", 8'h01, {7'h00, busy});
    end
    cmp8("fuse low", val[0], f_lo);
    cmp8("fuse high", val[1], f_hi);
    cmp8("fuse ext", val[2], f_ext);
    i_prog.load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_LOCK);
    i_prog.load(ppp_pkg::ACT_DATA, 1'b0, 8'hFC);
    i_prog.wr(busy);
    cmp8("locks set", 8'hFC, locks);
  endtask
  // eeprom byte kept through erase while locks clear and the low fuse stays
  task automatic t_erase();
    i_prog.load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_EEPROM);
    i_prog.load(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
    i_prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h05);
    i_prog.load(ppp_pkg::ACT_DATA, 1'b0, 8'h5A);
    i_prog.wr(busy);
    keep <= 1'b1;
    i_prog.load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_CHIP_ERASE);
    i_prog.wr(busy);
    cmp8("erase busy", 8'h01, {7'h00, busy});
    cmp8("locks erased", ppp_pkg::LOCK_ERASED, locks);
    cmp8("fuse kept", 8'h9A, f_lo);
    i_prog.load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_EEPROM);
    i_prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h05);
    i_prog.rd(1'b0, got);
    cmp8("eeprom kept", 8'h5A, got);
  endtask
  // two words of page 2, then a read that also hits an erased word
  task automatic t_flash();
    i_prog.load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FLASH);
    for (int i = 0; i < 2; i++) begin
      i_prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'(8'h21 + i));
      i_prog.load(ppp_pkg::ACT_DATA, 1'b0, 8'(8'h10 + i));
      i_prog.load(ppp_pkg::ACT_DATA, 1'b1, 8'(8'hC0 + i));
      i_prog.latch();
    end
    i_prog.load(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
    i_prog.wr(busy);
    cmp8("page busy", 8'h01, {7'h00, busy});
    i_prog.load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_NOP);
    i_prog.load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FLASH);
    for (int i = 0; i < 3; i++) begin
      i_prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'(8'h21 + i));
      i_prog.rd(1'b0, got);
      cmp8("flash low", i < 2 ? 8'(8'h10 + i) : ppp_pkg::ERASED_BYTE, got);
      i_prog.rd(1'b1, got);
      cmp8("flash high", i < 2 ? 8'(8'hC0 + i) : ppp_pkg::ERASED_BYTE, got);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // the run needs about 82k cycles; the limit allows 95k
  initial begin
    #475000;
    err_total++;
    close_out();
  end
  initial begin
    err_total = 0;
    checked = 0;
    rst_n_i = 1'b0;
    keep = 1'b0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_entry();
    t_fuse();
    t_erase();
    t_flash();
    close_out();
  end
endmodule
